/* File: ctm_pkg.sv */
// Constants package and the counter with its two comparators for the compact timer.
//
// How it works
// [R1] Mode field picks compare-match (00), timer/counter (11) or PWM (10) operation.
// [R2] Clear on comparator P or overflow when P is zero; raise both flags.
// [R3] Clearing on comparator A raises only the A flag, never the P flag.
// [R4] Clear on A with A value zero overflows at FFFF without an A flag.
// [R5] Compare-match pin changes only on an A flag event, never on P.
// [R6] Each A match drives the pin high, low or toggles it, or nothing.
// [R7] Enable rising edge loads the pin with the initial level bit.
// [R8] Timer/counter mode counts like compare-match mode but releases the pin.
// [R9] PWM ignores the clear select; the period register clears the counter.
// [R10] Swap zero: period is P times 256 (65536 for zero), duty is A.
// [R11] Duty at or above period keeps the PWM output active all the time.
// [R12] Swap one: period is A, duty is P times 256 or 65536.
// [R13] PWM mode raises the A and P flags on every matching comparator.
// [R14] PWM level bit picks active high or low; action passes or forces.
// [R15] The inversion bit inverts the final pin level.
// [R16] PWM counting and timing keep running while the pin is forced.
// [R17] Compare-match action codes: 00 none, 01 low, 10 high, 11 toggle.
// [R18] PWM action codes: 00 inactive, 01 active, 10 waveform, 11 undefined.
// [R19] The 8-bit P value is compared with counter bits 15 to 8 only.
// [R20] Enable rising edge zeroes the counter; disabled counter holds its value.
// [R21] Enabled counter steps on each timer tick; A matches the full count.
// [R22] Software changes mode and action only while the module is disabled.
`timescale 1ns/1ps

package ctm_pkg;

  // Register byte offsets on the bus.
  localparam logic [7:0] CTM_OFF_CTRL  = 8'h00;
  localparam logic [7:0] CTM_OFF_CMPA  = 8'h04;
  localparam logic [7:0] CTM_OFF_CMPP  = 8'h08;
  localparam logic [7:0] CTM_OFF_COUNT = 8'h0c;
  localparam logic [7:0] CTM_OFF_FLAGS = 8'h10;

  // Field positions inside the control register.
  localparam int CTM_BIT_CLR_A  = 0;
  localparam int CTM_BIT_SWAP   = 1;
  localparam int CTM_BIT_INV    = 2;
  localparam int CTM_BIT_LVL    = 3;
  localparam int CTM_BIT_ACT_LO = 4;
  localparam int CTM_BIT_ACT_HI = 5;
  localparam int CTM_BIT_MODE_LO = 6;
  localparam int CTM_BIT_MODE_HI = 7;
  localparam int CTM_BIT_EN     = 8;

  // Field positions inside the flag register.
  localparam int CTM_FLAG_A = 0;
  localparam int CTM_FLAG_P = 1;

  // Values after reset.
  localparam logic [15:0] CTM_RST_CMPA  = 16'h0000;
  localparam logic [7:0]  CTM_RST_CMPP  = 8'h00;
  localparam logic [15:0] CTM_RST_COUNT = 16'h0000;
  localparam logic [1:0]  CTM_RST_ACT   = 2'h0;

  // Full PWM span used when a P duty value of zero means 65536 clocks.
  localparam logic [16:0] CTM_FULL_SPAN = 17'h10000;

  // Operating modes.
  typedef enum logic [1:0] {
    CTM_MODE_CMP   = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM   = 2'b10,
    CTM_MODE_TMR   = 2'b11
  } ctm_mode_t;

  // Output action codes in compare-match mode.
  localparam logic [1:0] CTM_ACT_NONE   = 2'b00;
  localparam logic [1:0] CTM_ACT_LOW    = 2'b01;
  localparam logic [1:0] CTM_ACT_HIGH   = 2'b10;
  localparam logic [1:0] CTM_ACT_TOGGLE = 2'b11;

  // Output action codes in PWM mode.
  localparam logic [1:0] CTM_PWM_INACT = 2'b00;
  localparam logic [1:0] CTM_PWM_ACT   = 2'b01;
  localparam logic [1:0] CTM_PWM_WAVE  = 2'b10;

endpackage

module ctm_counter (
  // Clock, reset and enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Control from the register side.
  input  wire logic        restart_i,
  input  wire logic        step_i,
  input  wire logic        clr_on_a_i,
  input  wire logic [15:0] cmp_a_i,
  input  wire logic [7:0]  cmp_p_i,
  // Count and match pulses.
  output logic      [15:0] count_o,
  output logic             a_hit_o,
  output logic             p_hit_o
);

  logic [15:0] next_count;
  logic        next_a_hit;
  logic        next_p_hit;
  logic [15:0] inc;
  logic        a_eq;
  logic        p_eq;

  // Next count and comparator matches, judged on the value the count steps to.
  always_comb begin
    inc        = count_o + 16'h0001;
    // [R21] full A compare
    a_eq       = (inc == cmp_a_i);
    // [R19] P on top byte
    p_eq       = (inc[15:8] == cmp_p_i) && (inc[7:0] == 8'h00);
    next_count = count_o;
    next_a_hit = 1'b0;
    next_p_hit = 1'b0;
    // [R20] restart at zero
    if (restart_i) begin
      next_count = ctm_pkg::CTM_RST_COUNT;
    end else if (step_i) begin
      next_a_hit = a_eq;
      next_p_hit = p_eq;
      // [R2] clear or overflow
      if (clr_on_a_i ? a_eq : p_eq) begin
        next_count = ctm_pkg::CTM_RST_COUNT;
      end else begin
        next_count = inc;
      end
    end
  end

  // Counter and match pulse registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_o <= ctm_pkg::CTM_RST_COUNT;
      a_hit_o <= 1'b0;
      p_hit_o <= 1'b0;
    end else if (ce_i) begin
      count_o <= next_count;
      a_hit_o <= next_a_hit;
      p_hit_o <= next_p_hit;
    end
  end

endmodule

/* File: ctm_top.sv */
// Compact timer with compare-match, timer/counter and PWM modes behind a Wishbone slave.
`timescale 1ns/1ps

module ctm_top (
  // Clock, reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Selected timer clock, one-cycle pulse per count.
  input  wire logic        tick_i,
  // Wishbone classic slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Timer output pin.
  output logic             pin_o,
  output logic             pin_oe_n_o,
  // Match flags.
  output logic             a_flag_o,
  output logic             p_flag_o
);

  // Control register fields.
  ctm_pkg::ctm_mode_t ctrl_mode;
  ctm_pkg::ctm_mode_t next_mode;
  logic [1:0]         ctrl_act;
  logic [1:0]         next_act;
  logic               ctrl_lvl;
  logic               next_lvl;
  logic               ctrl_inv;
  logic               next_inv;
  logic               ctrl_swap;
  logic               next_swap;
  logic               ctrl_clr_a;
  logic               next_clr_a;
  logic               module_enable;
  logic               next_enable;
  logic [15:0]        cmp_a;
  logic [15:0]        next_cmp_a;
  logic [7:0]         cmp_p;
  logic [7:0]         next_cmp_p;

  // Bus and flag state.
  logic [31:0]        next_dat;
  logic               next_ack;
  logic               next_a_flag;
  logic               next_p_flag;

  // Counter side.
  logic               en_prev;
  logic               en_rise;
  logic               step;
  logic               clr_eff;
  logic               is_pwm;
  logic [15:0]        count;
  logic               a_hit;
  logic               p_hit;
  logic               set_a;
  logic               set_p;

  // Pin side.
  logic               pin_state;
  logic               next_pin_state;
  logic               next_pin;
  logic               next_oe_n;
  logic [16:0]        duty;
  logic               pwm_on;
  logic               req;
  logic               wr;

  // Request qualification: one answer per request, write acts on the answering edge.
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr  = req && wb_we_i;

  // [R1] mode decode
  assign is_pwm = (ctrl_mode == ctm_pkg::CTM_MODE_PWM);

  // [R9] period selects clear
  assign clr_eff = is_pwm ? ctrl_swap : ctrl_clr_a;

  // Enable edge and counting step.
  assign en_rise = module_enable && !en_prev;
  // [R16] count while forced
  assign step = module_enable && !en_rise && tick_i;

  // Flag raising per mode.
  always_comb begin
    // [R13] both flags in PWM
    set_a = a_hit;
    set_p = p_hit;
    if (!is_pwm) begin
      // [R3] no P flag
      if (ctrl_clr_a) begin
        set_p = 1'b0;
      end
      // [R4] no A flag on zero
      if (ctrl_clr_a && (cmp_a == 16'h0000)) begin
        set_a = 1'b0;
      end
    end
  end

  ctm_counter u_counter (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .restart_i  (en_rise),
    .step_i     (step),
    .clr_on_a_i (clr_eff),
    .cmp_a_i    (cmp_a),
    .cmp_p_i    (cmp_p),
    .count_o    (count),
    .a_hit_o    (a_hit),
    .p_hit_o    (p_hit)
  );

  // Register writes, reads and flag updates for the bus.
  always_comb begin
    next_mode   = ctrl_mode;
    next_act    = ctrl_act;
    next_lvl    = ctrl_lvl;
    next_inv    = ctrl_inv;
    next_swap   = ctrl_swap;
    next_clr_a  = ctrl_clr_a;
    next_enable = module_enable;
    next_cmp_a  = cmp_a;
    next_cmp_p  = cmp_p;
    next_a_flag = a_flag_o;
    next_p_flag = p_flag_o;
    next_dat    = 32'h0000_0000;
    next_ack    = req;
    if (wr) begin
      if (wb_adr_i == ctm_pkg::CTM_OFF_CTRL) begin
        if (wb_sel_i[0]) begin
          next_mode  = ctm_pkg::ctm_mode_t'(wb_dat_i[ctm_pkg::CTM_BIT_MODE_HI:
                                                    ctm_pkg::CTM_BIT_MODE_LO]);
          next_act   = wb_dat_i[ctm_pkg::CTM_BIT_ACT_HI:ctm_pkg::CTM_BIT_ACT_LO];
          next_lvl   = wb_dat_i[ctm_pkg::CTM_BIT_LVL];
          next_inv   = wb_dat_i[ctm_pkg::CTM_BIT_INV];
          next_swap  = wb_dat_i[ctm_pkg::CTM_BIT_SWAP];
          next_clr_a = wb_dat_i[ctm_pkg::CTM_BIT_CLR_A];
        end
        if (wb_sel_i[1]) begin
          next_enable = wb_dat_i[ctm_pkg::CTM_BIT_EN];
        end
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_CMPA) begin
        if (wb_sel_i[0]) begin
          next_cmp_a[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          next_cmp_a[15:8] = wb_dat_i[15:8];
        end
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_CMPP) begin
        if (wb_sel_i[0]) begin
          next_cmp_p = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_FLAGS) begin
        if (wb_sel_i[0] && wb_dat_i[ctm_pkg::CTM_FLAG_A]) begin
          next_a_flag = 1'b0;
        end
        if (wb_sel_i[0] && wb_dat_i[ctm_pkg::CTM_FLAG_P]) begin
          next_p_flag = 1'b0;
        end
      end
    end
    // A match in the same cycle as a clear keeps the flag set.
    if (set_a) begin
      next_a_flag = 1'b1;
    end
    if (set_p) begin
      next_p_flag = 1'b1;
    end
    if (req && !wb_we_i) begin
      if (wb_adr_i == ctm_pkg::CTM_OFF_CTRL) begin
        next_dat[ctm_pkg::CTM_BIT_MODE_HI:ctm_pkg::CTM_BIT_MODE_LO] = ctrl_mode;
        next_dat[ctm_pkg::CTM_BIT_ACT_HI:ctm_pkg::CTM_BIT_ACT_LO]   = ctrl_act;
        next_dat[ctm_pkg::CTM_BIT_LVL]   = ctrl_lvl;
        next_dat[ctm_pkg::CTM_BIT_INV]   = ctrl_inv;
        next_dat[ctm_pkg::CTM_BIT_SWAP]  = ctrl_swap;
        next_dat[ctm_pkg::CTM_BIT_CLR_A] = ctrl_clr_a;
        next_dat[ctm_pkg::CTM_BIT_EN]    = module_enable;
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_CMPA) begin
        next_dat[15:0] = cmp_a;
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_CMPP) begin
        next_dat[7:0] = cmp_p;
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_COUNT) begin
        next_dat[15:0] = count;
      end else if (wb_adr_i == ctm_pkg::CTM_OFF_FLAGS) begin
        next_dat[ctm_pkg::CTM_FLAG_A] = a_flag_o;
        next_dat[ctm_pkg::CTM_FLAG_P] = p_flag_o;
      end
    end
  end

  // Bus, control and flag registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_mode     <= ctm_pkg::CTM_MODE_CMP;
      ctrl_act      <= ctm_pkg::CTM_RST_ACT;
      ctrl_lvl      <= 1'b0;
      ctrl_inv      <= 1'b0;
      ctrl_swap     <= 1'b0;
      ctrl_clr_a    <= 1'b0;
      module_enable <= 1'b0;
      cmp_a         <= ctm_pkg::CTM_RST_CMPA;
      cmp_p         <= ctm_pkg::CTM_RST_CMPP;
      a_flag_o      <= 1'b0;
      p_flag_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      wb_ack_o      <= 1'b0;
      en_prev       <= 1'b0;
    end else if (ce_i) begin
      ctrl_mode     <= next_mode;
      ctrl_act      <= next_act;
      ctrl_lvl      <= next_lvl;
      ctrl_inv      <= next_inv;
      ctrl_swap     <= next_swap;
      ctrl_clr_a    <= next_clr_a;
      module_enable <= next_enable;
      cmp_a         <= next_cmp_a;
      cmp_p         <= next_cmp_p;
      a_flag_o      <= next_a_flag;
      p_flag_o      <= next_p_flag;
      wb_dat_o      <= next_dat;
      wb_ack_o      <= next_ack;
      en_prev       <= module_enable;
    end
  end

  // PWM duty threshold and waveform level from the running count.
  always_comb begin
    // [R10] duty from A
    duty = {1'b0, cmp_a};
    if (ctrl_swap) begin
      // [R12] duty from P
      duty = (cmp_p == 8'h00) ? ctm_pkg::CTM_FULL_SPAN : {1'b0, cmp_p, 8'h00};
    end
    // [R11] duty beyond period
    pwm_on = ({1'b0, count} < duty);
  end

  // Pin state per mode, then inversion and drive enable.
  always_comb begin
    next_pin_state = pin_state;
    if (en_rise) begin
      // [R7] initial level
      next_pin_state = ctrl_lvl;
    end else if (ctrl_mode == ctm_pkg::CTM_MODE_CMP) begin
      // [R5] A flag only
      if (set_a) begin
        // [R6] [R17] match action
        case (ctrl_act)
          ctm_pkg::CTM_ACT_LOW:    next_pin_state = 1'b0;
          ctm_pkg::CTM_ACT_HIGH:   next_pin_state = 1'b1;
          ctm_pkg::CTM_ACT_TOGGLE: next_pin_state = !pin_state;
          default:                 next_pin_state = pin_state;
        endcase
      end
    end else if (is_pwm && module_enable) begin
      // [R14] [R18] polarity and force
      case (ctrl_act)
        ctm_pkg::CTM_PWM_ACT:  next_pin_state = ctrl_lvl;
        ctm_pkg::CTM_PWM_WAVE: next_pin_state = pwm_on ? ctrl_lvl : !ctrl_lvl;
        default:               next_pin_state = !ctrl_lvl;
      endcase
    end
    // [R8] release pin
    next_oe_n = !((ctrl_mode == ctm_pkg::CTM_MODE_CMP) || is_pwm);
    // [R15] final inversion
    next_pin  = next_oe_n ? 1'b0 : (pin_state ^ ctrl_inv);
  end

  // Pin registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_state  <= 1'b0;
      pin_o      <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      pin_state  <= next_pin_state;
      pin_o      <= next_pin;
      pin_oe_n_o <= next_oe_n;
    end
  end

  // Checks on the behaviour above.
  a_bus_ack_next: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && req) |=> wb_ack_o)
    else $error("bus answer not one cycle after request");

  a_bus_ack_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && wb_ack_o) |=> !wb_ack_o)
    else $error("bus answer held longer than one cycle");

  a_timer_pin_free: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    (ce_i && ctrl_mode == ctm_pkg::CTM_MODE_TMR) |=> (pin_oe_n_o && !pin_o))
    else $error("pin driven in timer mode");

  a_enable_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (ce_i && en_rise) |=> (count == 16'h0000))
    else $error("counter not zero after enable rise");

  a_disabled_hold: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    (ce_i && !module_enable) |=> $stable(count))
    else $error("counter moved while disabled");

  a_init_level: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    (ce_i && en_rise) |=> (pin_state == $past(ctrl_lvl)))
    else $error("pin not at initial level after enable rise");

  a_p_flag_block: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
    (ce_i && p_hit && ctrl_clr_a && !is_pwm && !p_flag_o) |=> !p_flag_o)
    else $error("P flag raised while clearing on A");

  a_a_zero_silent: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (ce_i && a_hit && ctrl_clr_a && !is_pwm && cmp_a == 16'h0000 && !a_flag_o)
      |=> !a_flag_o)
    else $error("A flag raised with A value zero");

  a_pwm_flags: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (ce_i && is_pwm && a_hit) |=> a_flag_o)
    else $error("PWM A match did not raise the A flag");

  a_pwm_p_flag: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
    (ce_i && is_pwm && p_hit) |=> p_flag_o)
    else $error("PWM P match did not raise the P flag");

  a_toggle_action: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    (ce_i && ctrl_mode == ctm_pkg::CTM_MODE_CMP && set_a && !en_rise
      && ctrl_act == ctm_pkg::CTM_ACT_TOGGLE) |=> (pin_state != $past(pin_state)))
    else $error("toggle action did not toggle the pin");

  a_p_period_clear: assert property (@(posedge clk_i) disable iff (rst_i) // [R19]
    (ce_i && step && !clr_eff && count == ({cmp_p, 8'h00} - 16'h0001))
      |=> (count == 16'h0000 && p_hit))
    else $error("counter not cleared on P period match");

  a_pwm_forced: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (ce_i && is_pwm && module_enable && !en_rise && ctrl_act == ctm_pkg::CTM_PWM_ACT)
      |=> (pin_state == $past(ctrl_lvl)))
    else $error("forced PWM level not held");

endmodule

/* File: ctm_pin_load.sv */
// Board load on the timer output pin, with a pull-down on the pad.
`timescale 1ns/1ps

module ctm_pin_load (
  // Pin as driven by the timer.
  input  wire logic pin_i,
  input  wire logic oe_n_i,
  // Level seen on the board.
  output logic      pad_o
);
  // The pull-down sets the pad level whenever the timer releases the pin.
  assign pad_o = oe_n_i ? 1'b0 : pin_i;
endmodule

/* File: testbench.sv */
// Self-checking bench for the compact timer through its Wishbone slave.
`timescale 1ns/1ps

module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        ce;
  logic        tick;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        pin;
  logic        oe_n;
  logic        a_flag;
  logic        p_flag;
  logic        pad;
  logic [31:0] q;
  int          errors;
  int          n_tests;

  ctm_top u_ctm_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .tick_i(tick),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_o(pin),
    .pin_oe_n_o(oe_n), .a_flag_o(a_flag), .p_flag_o(p_flag));

  ctm_pin_load u_ctm_pin_load (.pin_i(pin), .oe_n_i(oe_n), .pad_o(pad));

  // Free-running 40 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is seen at an edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 16);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      errors++;
      print_verdict();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(q, e);
  endtask

  // Holds the timer clock high for exactly n edges.
  task automatic ticks(input int n);
    tick <= 1'b1;
    repeat (n) @(posedge clk_i);
    tick <= 1'b0;
  endtask

  // Control word: mode, action, then level, inversion, swap, clear select.
  function automatic logic [31:0] mk(input logic [1:0] m, input logic [1:0] a,
                                     input logic [3:0] f);
    return {24'h0, m, a, f};
  endfunction

  task automatic cfg(input logic [31:0] c, input logic [31:0] a, input logic [31:0] p);
    wr(8'h00, 32'h0);
    wr(8'h04, a);
    wr(8'h08, p);
    wr(8'h10, 32'h3);
    wr(8'h00, c);
    wr(8'h00, c | 32'h100);
  endtask

  // Counts high pin cycles over one PWM period, then checks both flags.
  task automatic pwm(input logic [31:0] c, input logic [31:0] a, input logic [31:0] p,
                     input int per, input int exp_h, input logic [1:0] ef);
    int h;
    cfg(c, a, p);
    tick <= 1'b1;
    repeat (8) @(posedge clk_i);
    h = 0;
    repeat (per) begin
      @(posedge clk_i);
      if (pin === 1'b1) h++;
    end
    tick <= 1'b0;
    check(32'(h), 32'(exp_h));
    check({30'h0, p_flag, a_flag}, {30'h0, ef});
  endtask

  // Main sequence.
  initial begin
    rst_i = 1'b1;
    tick = 1'b0;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    errors = 0;
    n_tests = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
    wr(8'h04, 32'h1234);
    rd_chk(8'h04, 32'h1234);
    wr(8'h0c, 32'h55);
    rd_chk(8'h0c, 32'h0);
    wr(8'h14, 32'h77);
    rd_chk(8'h14, 32'h0);
    for (int i = 0; i < 5; i++) begin
      cfg(mk(2'b00, 2'(i), {i[1:0] != 2'b10, i == 4, 2'b01}), 32'h3, 32'h0);
      repeat (3) @(posedge clk_i);
      check(32'(pin), 32'((i[1:0] != 2'b10) ^ (i == 4)));
      ticks(3);
      repeat (4) @(posedge clk_i);
      check(32'(pin), 32'(5'b00101 >> i) & 32'h1);
      check({30'h0, p_flag, a_flag}, 32'h1);
    end
    cfg(mk(2'b00, 2'b11, 4'b0001), 32'h300, 32'h1);
    ticks(770);
    repeat (4) @(posedge clk_i);
    check({30'h0, p_flag, a_flag}, 32'h1);
    check(32'(pin), 32'h1);
    rd_chk(8'h0c, 32'h2);
    cfg(mk(2'b00, 2'b11, 4'b0000), 32'h200, 32'h1);
    ticks(300);
    repeat (4) @(posedge clk_i);
    check({30'h0, p_flag, a_flag}, 32'h2);
    check(32'(pin), 32'h0);
    rd_chk(8'h0c, 32'h2c);
    rd_chk(8'h10, 32'h2);
    wr(8'h10, 32'h2);
    rd_chk(8'h10, 32'h0);
    cfg(mk(2'b00, 2'b11, 4'b0001), 32'h0, 32'h0);
    ticks(65836);
    repeat (4) @(posedge clk_i);
    check({30'h0, p_flag, a_flag}, 32'h0);
    check(32'(pin), 32'h0);
    rd_chk(8'h0c, 32'h12c);
    wr(8'h00, mk(2'b00, 2'b11, 4'b0001));
    ticks(10);
    rd_chk(8'h0c, 32'h12c);
    wr(8'h00, mk(2'b00, 2'b11, 4'b0001) | 32'h100);
    rd_chk(8'h0c, 32'h0);
    // Clock enable low freezes the count while ticks keep coming.
    ticks(4);
    @(posedge clk_i);
    ce <= 1'b0;
    ticks(5);
    ce <= 1'b1;
    rd_chk(8'h0c, 32'h4);
    for (int m = 0; m < 4; m++) begin
      cfg(mk(2'(m), 2'b11, 4'b0001), 32'h3, 32'h0);
      ticks(3);
      repeat (4) @(posedge clk_i);
      check(32'(oe_n), 32'(m % 2));
      check(32'(a_flag), 32'h1);
      if (m % 2 == 1) check(32'(pad), 32'h0);
    end
    pwm(mk(2'b10, 2'b10, 4'b1000), 32'h40, 32'h1, 256, 64, 2'b11);
    pwm(mk(2'b10, 2'b10, 4'b1000), 32'h200, 32'h1, 256, 256, 2'b10);
    pwm(mk(2'b10, 2'b10, 4'b1010), 32'h258, 32'h1, 600, 256, 2'b11);
    pwm(mk(2'b10, 2'b10, 4'b0000), 32'h40, 32'h1, 256, 192, 2'b11);
    pwm(mk(2'b10, 2'b00, 4'b1000), 32'h40, 32'h1, 256, 0, 2'b11);
    pwm(mk(2'b10, 2'b01, 4'b1000), 32'h40, 32'h1, 256, 256, 2'b11);
    pwm(mk(2'b10, 2'b11, 4'b1000), 32'h40, 32'h1, 256, 0, 2'b11);
    pwm(mk(2'b10, 2'b10, 4'b1100), 32'h40, 32'h1, 256, 192, 2'b11);
    pwm(mk(2'b10, 2'b10, 4'b1001), 32'h40, 32'h1, 256, 64, 2'b11);
    print_verdict();
  end
endmodule
